// ### rtl/fail_out_pkg.sv
// constants, register map and mode encodings of the fail output block
// assumes one 100 MHz clock; software reaches registers over AHB-Lite
// Summary of operation
// - three open-drain active-low fail outputs
// - watchdog fails count: cfg3/4 second, cfg1/2 first
// - thermal level two or regulator short activate
// - overvoltage activates only with reset enable
// - four consecutive undervoltages activate outputs
// - activation enters fail-safe mode simultaneously
// - activation sets failure status flag
// - force-on bit activates outputs for testing
// - release needs conditions gone and flag cleared
// - watchdog flag cleared on sleep/non-watchdog fail-safe, stop-off
// - config two first watchdog fail sets no flag
// - all outputs together; static output held low
// - blink output 1.25 Hz, half duty
// - pwm output runs at 100 Hz
// - duty select 20/10/5/2.5 percent, default 20
// - pins default fail outputs; control reassigns
// - wake-input pin detects wakes into wake status
// - switch pins current-limited only, no diagnosis
// - pin levels reported in normal and stop
// - config changes only in normal; wake kept
// - switch pins off in restart and fail-safe
// - failure-activated outputs persist through restart
package fail_out_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PIN_CFG = 8'h04;
  localparam logic [7:0] ADDR_DEVICE_STATUS_REGISTER = 8'h08;
  localparam logic [7:0] ADDR_WAKE_STAT = 8'h0c;
  localparam logic [7:0] ADDR_WAKE_LVL = 8'h10;
  localparam logic [7:0] ADDR_WD_STAT = 8'h14;
  // ctrl bits
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_OV_RST_BIT = 1;
  localparam int CTRL_DUTY_LSB = 2;
  localparam logic [1:0] DUTY_RESET = 2'h0;
  // pin function encodings
  typedef enum logic [1:0] {
    PIN_FAIL = 2'b00,
    PIN_WAKE = 2'b01,
    PIN_LOW_SIDE = 2'b10,
    PIN_HIGH_SIDE = 2'b11
  } pin_func_e;
  typedef enum logic [2:0] {
    MODE_INIT = 3'b000,
    MODE_NORMAL = 3'b001,
    MODE_STOP = 3'b010,
    MODE_SLEEP = 3'b011,
    MODE_RESTART = 3'b100,
    MODE_FAIL_SAFE = 3'b101
  } sbc_mode_e;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int BLINK_MHZ = 1250;
  localparam int PWM_HZ = 100;
  localparam int PWM_STEP_HZ = 4000;
  localparam int BLINK_HALF_CYC = CLK_HZ / (BLINK_MHZ * 2) * 1000;
  localparam int PWM_STEP_CYC = CLK_HZ / PWM_STEP_HZ;
  localparam logic [5:0] PWM_STEPS = 6'd40;
  localparam logic [5:0] DUTY20 = 6'd8;
  localparam logic [5:0] DUTY10 = 6'd4;
  localparam logic [5:0] DUTY5 = 6'd2;
  localparam logic [5:0] DUTY2P5 = 6'd1;
  localparam logic [2:0] UV_LIMIT = 3'd4;
  localparam logic [1:0] WD_CNT_RESET = 2'h0;
endpackage

// ### rtl/fail_out.sv
// fail output logic: failure latch, blink and pwm generators, pin functions
// assumes failure inputs from supervisors on the same clock, pins synced
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
module fail_out
  import fail_out_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_HALF_CYC,
  parameter int STEP_CYC = PWM_STEP_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // failure sources and chip state
  input wire logic watchdog_fail_flag_event,
  input wire logic wd_trigger_ok,
  input wire logic wd_disabled_stop,
  input wire logic thermal_shutdown_level_two,
  input wire logic main_regulator_short,
  input wire logic main_regulator_overvoltage,
  input wire logic main_regulator_undervoltage,
  input wire logic [1:0] hw_config,
  input wire logic [2:0] sbc_mode,
  output logic fail_safe_request,
  // pins: fail_static_out, blink pin, pwm pin
  output logic fail_static_out_oe,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic [1:0] high_side_on
);
  typedef struct packed {
    logic force_on;
    logic ov_rst_en;
    logic [1:0] duty;
    logic [1:0] func2;
    logic [1:0] func3;
    logic failure_flag;
    logic watchdog_fail_flag_flag;
    logic [1:0] wd_cnt;
    logic [2:0] uv_cnt;
    logic uv_prev;
    logic wd_prev;
    logic fail_act;
    logic [1:0] wake_stat;
    logic [1:0] pin_prev;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] lvl_stat;
    logic [26:0] blink_cnt;
    logic blink_ph;
    logic [19:0] step_cnt;
    logic [5:0] pwm_pos;
    logic ph_we;
    logic ph_act;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
  } state_s;
  state_s s_q, s_d;
  logic wd_hit, wd_sets_flag, cond_any, activate, normal;
  logic [5:0] duty_steps;
  logic [31:0] rd_mux;
  always_comb begin
    s_d = s_q;
    normal = (sbc_mode == MODE_NORMAL);
    // first sync stage only feeds the second
    s_d.pin_s1 = pin_in;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.wd_prev = watchdog_fail_flag_event;
    s_d.uv_prev = main_regulator_undervoltage;
    wd_hit = 1'b0;
    wd_sets_flag = 1'b0;
    if (watchdog_fail_flag_event && !s_q.wd_prev) begin
      if (hw_config[1]) begin
        wd_hit = (s_q.wd_cnt != WD_CNT_RESET);
      end else begin
        wd_hit = 1'b1;
      end
      // config two counts from zero; first fail sets no flag
      wd_sets_flag = wd_hit && !((hw_config == 2'd1) &&
        (s_q.wd_cnt == WD_CNT_RESET));
      if (s_q.wd_cnt != 2'h3) begin
        s_d.wd_cnt = s_q.wd_cnt + 2'h1;
      end
    end
    if (main_regulator_undervoltage && !s_q.uv_prev &&
        s_q.uv_cnt < UV_LIMIT) begin
      s_d.uv_cnt = s_q.uv_cnt + 3'd1;
    end
    cond_any = thermal_shutdown_level_two || main_regulator_short ||
      (main_regulator_overvoltage && s_q.ov_rst_en) ||
      (s_q.uv_cnt == UV_LIMIT) || s_q.watchdog_fail_flag_flag;
    activate = wd_hit || thermal_shutdown_level_two ||
      main_regulator_short ||
      (main_regulator_overvoltage && s_q.ov_rst_en) ||
      (s_q.uv_cnt == UV_LIMIT);
    // watchdog flag cleared by good trigger, sleep or non-watchdog_fail_flag-safe
    if (wd_trigger_ok || wd_disabled_stop ||
        sbc_mode == MODE_SLEEP ||
        (activate && !wd_hit)) begin
      s_d.watchdog_fail_flag_flag = 1'b0;
    end
    if (wd_hit) begin
      s_d.watchdog_fail_flag_flag = 1'b1;
    end
    if (wd_trigger_ok) begin
      s_d.wd_cnt = WD_CNT_RESET;
    end
    if (!main_regulator_undervoltage && s_q.uv_cnt != UV_LIMIT &&
        wd_trigger_ok) begin
      s_d.uv_cnt = 3'd0;
    end
    // bus write data phase; set beats clear
    if (s_q.ph_act && s_q.ph_we) begin
      case (s_q.ph_addr)
        ADDR_CTRL: begin
          s_d.force_on = hwdata[CTRL_FORCE_BIT];
          s_d.ov_rst_en = hwdata[CTRL_OV_RST_BIT];
          s_d.duty = hwdata[CTRL_DUTY_LSB+:2];
        end
        ADDR_PIN_CFG: begin
          if (normal) begin
            s_d.func2 = hwdata[1:0];
            s_d.func3 = hwdata[3:2];
          end
        end
        ADDR_DEVICE_STATUS_REGISTER: begin
          // host clears flag after watchdog flag is gone
          if (hwdata[0] && !s_q.watchdog_fail_flag_flag && !cond_any) begin
            s_d.failure_flag = 1'b0;
          end
          if (hwdata[1]) begin
            s_d.uv_cnt = 3'd0;
          end
        end
        ADDR_WAKE_STAT: begin
          s_d.wake_stat = s_q.wake_stat & ~hwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    if (activate && (!wd_hit || wd_sets_flag || !watchdog_fail_flag_event)) begin
      s_d.failure_flag = 1'b1;
    end
    if (wd_sets_flag) begin
      s_d.failure_flag = 1'b1;
    end
    if (activate) begin
      s_d.fail_act = 1'b1;
    end else if (normal && !s_q.failure_flag && !cond_any) begin
      s_d.fail_act = 1'b0;
    end
    // wake detection on rising or falling edge of wake-input pins
    for (int i = 0; i < 2; i++) begin
      if ((i == 0 ? s_q.func2 : s_q.func3) == PIN_WAKE &&
          sbc_mode != MODE_FAIL_SAFE &&
          s_q.pin_s2[i] != s_q.pin_prev[i]) begin
        s_d.wake_stat[i] = 1'b1;
      end
    end
    s_d.pin_prev = s_q.pin_s2;
    if (normal || sbc_mode == MODE_STOP) begin
      s_d.lvl_stat = s_q.pin_s2;
    end
    // blink generator
    if (s_q.blink_cnt >= 27'(BLINK_CYC - 1)) begin
      s_d.blink_cnt = 27'd0;
      s_d.blink_ph = !s_q.blink_ph;
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 27'd1;
    end
    // pwm generator: 40 steps per 10 ms period
    if (s_q.step_cnt >= 20'(STEP_CYC - 1)) begin
      s_d.step_cnt = 20'd0;
      if (s_q.pwm_pos == PWM_STEPS - 6'd1) begin
        s_d.pwm_pos = 6'd0;
      end else begin
        s_d.pwm_pos = s_q.pwm_pos + 6'd1;
      end
    end else begin
      s_d.step_cnt = s_q.step_cnt + 20'd1;
    end
    if (!(s_q.fail_act || s_q.force_on)) begin
      s_d.blink_cnt = 27'd0;
      s_d.blink_ph = 1'b0;
      s_d.step_cnt = 20'd0;
      s_d.pwm_pos = 6'd0;
    end
    // address phase capture
    if (hready) begin
      s_d.ph_act = hsel && htrans[1];
      s_d.ph_we = hwrite;
      s_d.ph_addr = haddr[7:0];
      s_d.rdata = rd_mux;
    end
  end
  always_comb begin
    case (haddr[7:0])
      ADDR_CTRL: rd_mux = {28'h0, s_q.duty, s_q.ov_rst_en, s_q.force_on};
      ADDR_PIN_CFG: rd_mux = {28'h0, s_q.func3, s_q.func2};
      ADDR_DEVICE_STATUS_REGISTER: rd_mux = {28'h0, s_q.uv_cnt == UV_LIMIT,
        s_q.fail_act, 1'b0, s_q.failure_flag};
      ADDR_WAKE_STAT: rd_mux = {30'h0, s_q.wake_stat};
      ADDR_WAKE_LVL: rd_mux = {30'h0, s_q.lvl_stat};
      ADDR_WD_STAT: rd_mux = {29'h0, s_q.wd_cnt, s_q.watchdog_fail_flag_flag};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  always_comb begin
    case (s_q.duty)
      2'd0: duty_steps = DUTY20;
      2'd1: duty_steps = DUTY10;
      2'd2: duty_steps = DUTY5;
      default: duty_steps = DUTY2P5;
    endcase
  end
  logic fail_on, pwm_low;
  logic [1:0] fail_drive;
  assign fail_on = s_q.fail_act || s_q.force_on;
  assign pwm_low = (s_q.pwm_pos < duty_steps);
  assign fail_drive = {fail_on && pwm_low, fail_on && !s_q.blink_ph};
  assign fail_static_out_oe = fail_on;
  assign fail_safe_request = s_q.fail_act;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_out[i] = 1'b0;
      pin_oe[i] = 1'b0;
      high_side_on[i] = 1'b0;
      case (i == 0 ? s_q.func2 : s_q.func3)
        PIN_FAIL: pin_oe[i] = fail_drive[i];
        PIN_LOW_SIDE: pin_oe[i] = !(sbc_mode == MODE_RESTART ||
          sbc_mode == MODE_FAIL_SAFE);
        PIN_HIGH_SIDE: begin
          high_side_on[i] = !(sbc_mode == MODE_RESTART ||
            sbc_mode == MODE_FAIL_SAFE);
          pin_out[i] = high_side_on[i];
        end
        default: pin_oe[i] = 1'b0;
      endcase
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
endmodule

// ### tb/fail_out_assertions.sv
// port checker for the fail output block
// assumes bind onto fail_out; counts follow its blink and step parameters
`timescale 1ns/100ps
module fail_out_assertions
  import fail_out_pkg::*;
#(
  parameter int BLINK_CYC = 20,
  parameter int STEP_CYC = 5
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // faults and fail outputs
  input wire logic thermal_shutdown_level_two,
  input wire logic main_regulator_short,
  input wire logic fail_safe_request,
  input wire logic fail_static_out_oe,
  input wire logic [1:0] pin_oe
);
  logic [15:0] blink_q, hi_q, lo_q;
  logic act;
  assign act = fail_static_out_oe;
  // run lengths of the blink and pwm drive while the fail state is on
  always_ff @(posedge hclk) begin
    blink_q <= (!act || $changed(pin_oe[0])) ? '0 : blink_q + 16'd1;
    hi_q <= (act && pin_oe[1]) ? hi_q + 16'd1 : '0;
    lo_q <= (act && !pin_oe[1]) ? lo_q + 16'd1 : '0;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence act_s;
    $rose(fail_static_out_oe);
  endsequence
  sequence hold_s;
    fail_static_out_oe [*8];
  endsequence
  fault_act_a:
  assert property ((thermal_shutdown_level_two || main_regulator_short)
    |-> ##[1:3] act) else $error("fault left outputs off");
  safe_entry_a:
  assert property ($rose(fail_safe_request) |-> act)
    else $error("fail-safe without outputs");
  fail_release_a:
  assert property ($fell(act) |-> !$past(thermal_shutdown_level_two)
    && !$past(main_regulator_short)) else $error("release under fault");
  static_hold_a:
  assert property (act_s |=> hold_s) else $error("static output dropped");
  outputs_together_a:
  assert property (act_s |-> pin_oe[0]) else $error("blink pin late");
  blink_toggle_a:
  assert property (blink_q < BLINK_CYC + 2) else $error("blink stuck");
  pwm_high_a:
  assert property (hi_q <= int'(DUTY20) * STEP_CYC)
    else $error("pwm on too long");
  pwm_low_a:
  assert property (lo_q < int'(PWM_STEPS) * STEP_CYC)
    else $error("pwm off too long");
endmodule
bind fail_out fail_out_assertions #(.BLINK_CYC(BLINK_CYC),
  .STEP_CYC(STEP_CYC)) i_chk (.hclk, .hresetn,
  .thermal_shutdown_level_two, .main_regulator_short,
  .fail_safe_request, .fail_static_out_oe, .pin_oe);

// ### tb/lamp_load.sv
// lamp loads with pull-ups on the two shared pins
// assumes a released or undriven line rises to the pull-up level
`timescale 1ns/100ps
module lamp_load (
  // pin drive
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic [1:0] high_side_on,
  // outside contact that pulls a line low
  input wire logic [1:0] ext_low,
  // line levels
  output logic [1:0] pin_in
);
  assign pin_in = (high_side_on | (pin_oe & pin_out) | ~pin_oe) & ~ext_low;
endmodule

// ### tb/fail_out_logic_test.sv
// self-checking bench of the fail output block
// assumes the small blink and step counts set on the instance below
`timescale 1ns/100ps
module fail_output_gpio_logic_test;
  import fail_out_pkg::*;
  localparam int STEP = 5;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_ph = 0, wds = 0;
  logic [31:0] haddr = '0, hwdata = '0, n, m;
  logic [1:0] htrans = '0, hw_config = '0, low = '0;
  logic [2:0] hsize = 3'h2, ev = '0, flt = '0, sbc_mode = MODE_NORMAL;
  wire hreadyout, hresp, fail_safe_request, fail_static_out_oe;
  wire [31:0] hrdata;
  wire [1:0] pin_in, pin_out, pin_oe, high_side_on;
  logic [31:0] exp_q[$];
  int fail_count = 0, tests_run = 0, seed = 22648;
  fail_out #(.BLINK_CYC(20), .STEP_CYC(STEP)) i_dut (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .watchdog_fail_flag_event(ev[0]),
    .wd_trigger_ok(ev[2]), .wd_disabled_stop(wds),
    .thermal_shutdown_level_two(flt[0]), .main_regulator_short(flt[1]),
    .main_regulator_overvoltage(flt[2]),
    .main_regulator_undervoltage(ev[1]), .hw_config, .sbc_mode,
    .fail_safe_request, .fail_static_out_oe, .pin_in, .pin_out, .pin_oe,
    .high_side_on);
  lamp_load i_load (.pin_out, .pin_oe, .high_side_on, .ext_low(low),
    .pin_in);
  always #5 hclk = ~hclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask
  // one single-word transfer; a read notes its expected word
  task automatic bus(input logic [7:0] a, input logic w,
      input logic [31:0] d, input logic [31:0] e);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    if (!w)
      exp_q.push_back(e);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  task automatic kick(input int i);
    ev[i] <= 1'b1;
    cyc(2);
    ev[i] <= 1'b0;
    cyc(2);
  endtask
  always @(posedge hclk) begin
    if (rd_ph)
      chk(hrdata, exp_q.pop_front());
  end
  initial begin
    cyc(60000);
    fail_count++;
    print_verdict;
  end
  initial begin
    cyc(6);
    hresetn <= 1'b1;
    bus(ADDR_CTRL, 0, 0, 0);
    bus(ADDR_PIN_CFG, 0, 0, 0);
    bus(8'h20, 1, $random(seed), 0);
    bus(8'h20, 0, 0, 0);
    bus(ADDR_CTRL, 1, 1, 0);
    cyc(10);
    chk(fail_static_out_oe, 1);
    bus(ADDR_CTRL, 1, 0, 0);
    cyc(3);
    chk(fail_static_out_oe, 0);
    for (int k = 0; k < 2; k++) begin
      flt[k] <= 1'b1;
      cyc(3);
      chk(fail_safe_request, 1);
      bus(ADDR_DEVICE_STATUS_REGISTER, 0, 0, 32'h5);
      bus(ADDR_DEVICE_STATUS_REGISTER, 1, 1, 0);
      sbc_mode <= MODE_RESTART;
      cyc(300);
      sbc_mode <= MODE_NORMAL;
      flt[k] <= 1'b0;
      cyc(3);
      chk(fail_static_out_oe, 1);
      bus(ADDR_DEVICE_STATUS_REGISTER, 1, 1, 0);
      cyc(3);
      chk(fail_static_out_oe, 0);
    end
    for (int i = 0; i < 2; i++) begin
      bus(ADDR_CTRL, 1, 32'(i) << 1, 0);
      flt[2] <= 1'b1;
      cyc(12);
      chk(fail_static_out_oe, i);
      flt[2] <= 1'b0;
      bus(ADDR_DEVICE_STATUS_REGISTER, 1, 1, 0);
      cyc(3);
    end
    for (int i = 1; i < 5; i++) begin
      kick(1);
      chk(fail_static_out_oe, i == 4);
    end
    cyc(8);
    // count must be gone before the flag may be cleared
    bus(ADDR_DEVICE_STATUS_REGISTER, 1, 2, 0);
    bus(ADDR_DEVICE_STATUS_REGISTER, 1, 1, 0);
    cyc(3);
    chk(fail_static_out_oe, 0);
    for (int c = 0; c < 4; c++) begin
      hw_config <= 2'(c);
      kick(0);
      chk(fail_static_out_oe, c < 2);
      bus(ADDR_DEVICE_STATUS_REGISTER, 0, 0, c == 0 ? 5 : c == 1 ? 4 : 0);
      kick(0);
      chk(fail_static_out_oe, 1);
      cyc(8);
      if (c == 0) begin
        wds <= 1'b1;
        bus(ADDR_WD_STAT, 0, 0, 32'h4);
        wds <= 1'b0;
      end
      kick(2);
      bus(ADDR_WD_STAT, 0, 0, 0);
      bus(ADDR_DEVICE_STATUS_REGISTER, 1, 1, 0);
      cyc(3);
      chk(fail_static_out_oe, 0);
    end
    for (int d = 0; d < 4; d++) begin
      bus(ADDR_CTRL, 1, 32'(d) << 2 | 1, 0);
      cyc(200);
      n = 0;
      m = 0;
      repeat (200) begin
        @(posedge hclk);
        n += pin_oe[1];
        m += pin_oe[0];
      end
      chk(n, (8 >> d) * STEP);
      chk(m, 100);
    end
    bus(ADDR_CTRL, 1, 0, 0);
    bus(ADDR_PIN_CFG, 1, 32'h1, 0);
    low[0] <= 1'b1;
    cyc(4);
    bus(ADDR_WAKE_STAT, 0, 0, 32'h1);
    bus(ADDR_WAKE_STAT, 1, 32'h1, 0);
    bus(ADDR_WAKE_STAT, 0, 0, 32'h0);
    low[0] <= 1'b0;
    cyc(4);
    bus(ADDR_PIN_CFG, 1, 32'h0, 0);
    sbc_mode <= MODE_STOP;
    bus(ADDR_PIN_CFG, 1, 32'he, 0);
    bus(ADDR_PIN_CFG, 0, 0, 0);
    sbc_mode <= MODE_NORMAL;
    bus(ADDR_PIN_CFG, 1, 32'he, 0);
    cyc(4);
    chk({high_side_on[1], pin_oe[0], pin_out[0]}, 3'b110);
    bus(ADDR_WAKE_LVL, 0, 0, 2);
    sbc_mode <= MODE_RESTART;
    cyc(2);
    chk({high_side_on[1], pin_oe[0]}, 0);
    sbc_mode <= MODE_NORMAL;
    cyc(2);
    chk({high_side_on[1], pin_oe[0]}, 3);
    bus(ADDR_PIN_CFG, 0, 0, 32'he);
    cyc(2);
    print_verdict;
  end
endmodule
